//--- rtl/pdsp_pkg.sv
package pdsp_pkg;
  // Lane and bus widths
  localparam int LANES = 8;
  localparam int DEBUG_W = 16;
  localparam int RCFG_AW = 9;
  localparam int RCFG_DW = 16;
  localparam int RCFG_DEPTH = 512;
  // Link reset symbols needed back to back before the indication rises
  localparam logic [2:0] LINK_RESET_MIN = 3'h4;
  // Reconfiguration wait cycles loaded at the taken enable; done follows four cycles after it
  localparam logic [1:0] RCFG_LAT = 2'h2;
  // Reset values
  localparam logic [LANES-1:0] LANE_CLEAR = 8'h00;
  localparam logic [RCFG_DW-1:0] DATA_CLEAR = 16'h0000;
  // Debug vector field positions
  localparam int DBG_MCE = 0;
  localparam int DBG_LRST = 1;
  localparam int DBG_IRQ = 2;
  localparam int DBG_RBUSY = 3;
  localparam int DBG_DISP_ANY = 4;
  localparam int DBG_DEC_ANY = 5;
  localparam int DBG_LRCNT_LO = 8;
  localparam int DBG_LRCNT_HI = 10;
  // Interrupt status and mask bit positions
  localparam int EV_MCE = 0;
  localparam int EV_LRST = 1;
  localparam int EV_DISP = 2;
  localparam int EV_DEC = 3;
  localparam int EV_W = 4;
  // Register offsets on the software port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_DISP = 4'h2;
  localparam logic [3:0] REG_DEC = 4'h3;
  localparam logic [3:0] REG_DEBUG = 4'h4;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  // Reconfiguration engine states
  typedef enum logic [2:0] {
    RC_IDLE = 3'b001,
    RC_WAIT = 3'b010,
    RC_DONE = 3'b100
  } pdsp_rc_state_t;
endpackage : pdsp_pkg

//--- rtl/pdsp_cfg_mem.sv
`timescale 1ns/10ps
// Transceiver configuration store; read data leave a register
module pdsp_cfg_mem (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [pdsp_pkg::RCFG_AW-1:0] addr,
  input wire logic [pdsp_pkg::RCFG_DW-1:0] wrData,
  output logic [pdsp_pkg::RCFG_DW-1:0] rdData
);
  logic [pdsp_pkg::RCFG_DW-1:0] mem [pdsp_pkg::RCFG_DEPTH];

  // Write port, no reset on the array so it maps to block memory
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (rdEn) begin
      rdData <= mem[addr];
    end
  end
endmodule : pdsp_cfg_mem

//--- rtl/pdsp_debug_port.sv
// Overview of operation
// - One disparity-error flag per received byte lane, bit 0 for the low byte.
// - One decode-error flag per received byte lane for bytes not in the code table.
// - Link-reset-received rises only after four back-to-back error-free reset symbols.
// - Multicast-event-received pulses whenever such a control symbol arrives without an error.
// - Write data come on a data-in bus, read data leave on a data-out bus, write select picks a write.
// - Done marks a completed write or valid read data.
// - Debug vector and per-byte error vectors are presented from registers.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
module pdsp_debug_port (
  input wire logic clk,
  input wire logic rst_n,
  // Received lane status from the transceiver, asynchronous to clk
  input wire logic [pdsp_pkg::LANES-1:0] laneDispErr,
  input wire logic [pdsp_pkg::LANES-1:0] laneDecodeErr,
  // Control symbol strobes from the PHY receive path, same clock
  input wire logic symValid,
  input wire logic symIsLinkReset,
  input wire logic symIsMce,
  input wire logic symErr,
  // Status outputs
  output logic [pdsp_pkg::LANES-1:0] dispErrFlags,
  output logic [pdsp_pkg::LANES-1:0] decodeErrFlags,
  output logic rcvdMce,
  output logic rcvdLinkReset,
  output logic [pdsp_pkg::DEBUG_W-1:0] phyDebug,
  // Reconfiguration port
  input wire logic reconfig_enable,
  input wire logic reconfig_write_sel,
  input wire logic [pdsp_pkg::RCFG_AW-1:0] reconfig_addr,
  input wire logic [pdsp_pkg::RCFG_DW-1:0] reconfig_wr_data,
  output logic [pdsp_pkg::RCFG_DW-1:0] reconfig_rd_data,
  output logic reconfig_done,
  // Software register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq
);
  logic [pdsp_pkg::LANES-1:0] dispMeta_ff;
  logic [pdsp_pkg::LANES-1:0] dispSync_ff;
  logic [pdsp_pkg::LANES-1:0] decMeta_ff;
  logic [pdsp_pkg::LANES-1:0] decSync_ff;
  logic [2:0] lrCount_ff;
  logic [2:0] nxt_lrCount;
  logic [pdsp_pkg::EV_W-1:0] status_ff;
  logic [pdsp_pkg::EV_W-1:0] mask_ff;
  logic [pdsp_pkg::EV_W-1:0] events;
  logic [7:0] nxt_statusWide;
  logic [pdsp_pkg::LANES-1:0] dispSticky_ff;
  logic [pdsp_pkg::LANES-1:0] decSticky_ff;
  pdsp_pkg::pdsp_rc_state_t rcState_ff;
  logic [1:0] rcWait_ff;
  logic rcWrite_ff;
  logic [pdsp_pkg::RCFG_AW-1:0] rcAddr_ff;
  logic [pdsp_pkg::RCFG_DW-1:0] rcData_ff;
  logic memWr;
  logic memRd;
  logic [pdsp_pkg::RCFG_DW-1:0] memRdData;
  logic rcTake;

  // Write-one-to-clear update of a status vector; used for every write-one-to-clear field
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = (cur & ~clr) | set; // Set wins over a clear in the same cycle
  endfunction : w1c

  // Two-stage synchronisers for the asynchronous lane error inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dispMeta_ff <= pdsp_pkg::LANE_CLEAR;
      dispSync_ff <= pdsp_pkg::LANE_CLEAR;
      decMeta_ff <= pdsp_pkg::LANE_CLEAR;
      decSync_ff <= pdsp_pkg::LANE_CLEAR;
    end else begin
      dispMeta_ff <= laneDispErr;
      dispSync_ff <= dispMeta_ff;
      decMeta_ff <= laneDecodeErr;
      decSync_ff <= decMeta_ff;
    end
  end

  // Per-lane error flags, one bit per byte lane, registered for output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dispErrFlags <= pdsp_pkg::LANE_CLEAR;
      decodeErrFlags <= pdsp_pkg::LANE_CLEAR;
    end else begin
      dispErrFlags <= dispSync_ff;
      decodeErrFlags <= decSync_ff;
    end
  end

  // Run of back-to-back clean link reset symbols; any other symbol breaks it
  always_comb begin
    nxt_lrCount = lrCount_ff;
    if (symValid) begin
      if (symIsLinkReset && !symErr) begin
        if (lrCount_ff != pdsp_pkg::LINK_RESET_MIN) begin
          nxt_lrCount = lrCount_ff + 3'h1; // Saturates at the threshold
        end
      end else begin
        nxt_lrCount = 3'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lrCount_ff <= 3'h0;
    end else begin
      lrCount_ff <= nxt_lrCount;
    end
  end

  // Indication stays up while the run lasts and drops when it breaks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcvdLinkReset <= 1'b0;
    end else begin
      rcvdLinkReset <= (nxt_lrCount == pdsp_pkg::LINK_RESET_MIN);
    end
  end

  // One-cycle pulse per multicast-event symbol; errored symbols are dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcvdMce <= 1'b0;
    end else begin
      rcvdMce <= symValid && symIsMce && !symErr;
    end
  end

  // Event sources for the interrupt status register
  always_comb begin
    events = '0;
    events[pdsp_pkg::EV_MCE] = symValid && symIsMce && !symErr;
    events[pdsp_pkg::EV_LRST] = (nxt_lrCount == pdsp_pkg::LINK_RESET_MIN) && !rcvdLinkReset;
    events[pdsp_pkg::EV_DISP] = |dispSync_ff;
    events[pdsp_pkg::EV_DEC] = |decSync_ff;
  end

  // Status next value kept wide; a part-select cannot be taken of a call directly
  assign nxt_statusWide = w1c({4'h0, status_ff}, {4'h0, events},
                              (regWr && regAddr == pdsp_pkg::REG_STATUS) ?
                              {4'h0, regWrData[pdsp_pkg::EV_W-1:0]} : 8'h00);

  // Sticky status, mask and per-lane sticky error capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= '0;
      mask_ff <= pdsp_pkg::MASK_RESET;
      dispSticky_ff <= pdsp_pkg::LANE_CLEAR;
      decSticky_ff <= pdsp_pkg::LANE_CLEAR;
    end else begin
      status_ff <= nxt_statusWide[pdsp_pkg::EV_W-1:0];
      dispSticky_ff <= w1c(dispSticky_ff, dispSync_ff,
                           (regWr && regAddr == pdsp_pkg::REG_DISP) ?
                           regWrData[pdsp_pkg::LANES-1:0] : 8'h00);
      decSticky_ff <= w1c(decSticky_ff, decSync_ff,
                          (regWr && regAddr == pdsp_pkg::REG_DEC) ?
                          regWrData[pdsp_pkg::LANES-1:0] : 8'h00);
      if (regWr && regAddr == pdsp_pkg::REG_MASK) begin
        mask_ff <= regWrData[pdsp_pkg::EV_W-1:0];
      end
    end
  end

  // Level interrupt from unmasked sticky status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_ff & mask_ff);
    end
  end

  // Register read mux; unmapped offsets read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        pdsp_pkg::REG_STATUS: regRdData <= {28'h0000000, status_ff};
        pdsp_pkg::REG_MASK: regRdData <= {28'h0000000, mask_ff};
        pdsp_pkg::REG_DISP: regRdData <= {24'h000000, dispSticky_ff};
        pdsp_pkg::REG_DEC: regRdData <= {24'h000000, decSticky_ff};
        pdsp_pkg::REG_DEBUG: regRdData <= {16'h0000, phyDebug};
        default: regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000; // Data stand only in the cycle after the strobe
    end
  end

  // Debug status vector gathering the block's own state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phyDebug <= '0;
    end else begin
      phyDebug <= '0;
      phyDebug[pdsp_pkg::DBG_MCE] <= rcvdMce;
      phyDebug[pdsp_pkg::DBG_LRST] <= rcvdLinkReset;
      phyDebug[pdsp_pkg::DBG_IRQ] <= irq;
      phyDebug[pdsp_pkg::DBG_RBUSY] <= (rcState_ff != pdsp_pkg::RC_IDLE);
      phyDebug[pdsp_pkg::DBG_DISP_ANY] <= |dispSticky_ff;
      phyDebug[pdsp_pkg::DBG_DEC_ANY] <= |decSticky_ff;
      phyDebug[pdsp_pkg::DBG_LRCNT_HI:pdsp_pkg::DBG_LRCNT_LO] <= lrCount_ff;
    end
  end

  // Accesses are only taken when idle; an enable while busy is ignored
  assign rcTake = reconfig_enable && (rcState_ff == pdsp_pkg::RC_IDLE);

  // Reconfiguration engine: capture, fixed latency, then a one-cycle done
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcState_ff <= pdsp_pkg::RC_IDLE;
      rcWait_ff <= 2'h0;
      rcWrite_ff <= 1'b0;
      rcAddr_ff <= '0;
      rcData_ff <= pdsp_pkg::DATA_CLEAR;
    end else begin
      case (rcState_ff)
        pdsp_pkg::RC_IDLE: begin
          if (rcTake) begin
            rcWrite_ff <= reconfig_write_sel;
            rcAddr_ff <= reconfig_addr;
            rcData_ff <= reconfig_wr_data;
            rcWait_ff <= pdsp_pkg::RCFG_LAT;
            rcState_ff <= pdsp_pkg::RC_WAIT;
          end
        end
        pdsp_pkg::RC_WAIT: begin
          rcWait_ff <= rcWait_ff - 2'h1;
          if (rcWait_ff == 2'h1) begin
            rcState_ff <= pdsp_pkg::RC_DONE;
          end
        end
        pdsp_pkg::RC_DONE: begin
          rcState_ff <= pdsp_pkg::RC_IDLE;
        end
        default: begin
          rcState_ff <= pdsp_pkg::RC_IDLE;
        end
      endcase
    end
  end

  // Memory strobes fire once, on the last wait cycle
  assign memWr = (rcState_ff == pdsp_pkg::RC_WAIT) && (rcWait_ff == 2'h1) && rcWrite_ff;
  assign memRd = (rcState_ff == pdsp_pkg::RC_WAIT) && (rcWait_ff == 2'h1) && !rcWrite_ff;

  pdsp_cfg_mem u_cfgMem (
    .clk(clk),
    .wrEn(memWr),
    .rdEn(memRd),
    .addr(rcAddr_ff),
    .wrData(rcData_ff),
    .rdData(memRdData)
  );

  // Done pulse and read data; read data hold until the next read completes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reconfig_done <= 1'b0;
      reconfig_rd_data <= pdsp_pkg::DATA_CLEAR;
    end else begin
      reconfig_done <= (rcState_ff == pdsp_pkg::RC_DONE);
      if ((rcState_ff == pdsp_pkg::RC_DONE) && !rcWrite_ff) begin
        reconfig_rd_data <= memRdData;
      end
    end
  end
endmodule : pdsp_debug_port

//--- test/pdsp_debug_checker.sv
`timescale 1ns/10ps
module pdsp_debug_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pdsp_pkg::LANES-1:0] laneDispErr,
  input wire logic [pdsp_pkg::LANES-1:0] laneDecodeErr,
  input wire logic symValid,
  input wire logic symIsLinkReset,
  input wire logic symIsMce,
  input wire logic symErr,
  input wire logic [pdsp_pkg::LANES-1:0] dispErrFlags,
  input wire logic [pdsp_pkg::LANES-1:0] decodeErrFlags,
  input wire logic rcvdMce,
  input wire logic rcvdLinkReset,
  input wire logic reconfig_enable,
  input wire logic [pdsp_pkg::RCFG_DW-1:0] reconfig_rd_data,
  input wire logic reconfig_done,
  input wire logic regRd,
  input wire logic [31:0] regRdData
);
  logic [2:0] rcCnt_ff;
  logic take;
  logic lrClean;
  logic mceClean;
  // Countdown ties each done to the enable that started it; enable in the done cycle is taken
  assign take = reconfig_enable && (rcCnt_ff <= 3'h1);
  assign lrClean = symValid && symIsLinkReset && !symErr;
  assign mceClean = symValid && symIsMce && !symErr;
  always_ff @(posedge clk) begin
    if (!rst_n) rcCnt_ff <= 3'h0;
    else if (take) rcCnt_ff <= 3'h4;
    else if (rcCnt_ff != 3'h0) rcCnt_ff <= rcCnt_ff - 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Link reset runs, complete and broken
  sequence s_lr4; lrClean [*4]; endsequence
  sequence s_lr3_break; lrClean [*3] ##1 (symValid && !lrClean); endsequence
  property p_lr_set; s_lr4 |=> rcvdLinkReset; endproperty
  property p_lr_drop; s_lr3_break |=> !rcvdLinkReset; endproperty
  property p_lr_rise; $rose(rcvdLinkReset) |-> $past(lrClean); endproperty
  property p_mce; mceClean |=> rcvdMce; endproperty
  property p_mce_only; rcvdMce |-> $past(mceClean); endproperty
  // Five steady cycles cover the synchroniser and the output register
  property p_disp; $stable(laneDispErr) [*5] |-> dispErrFlags == laneDispErr; endproperty
  property p_dec; $stable(laneDecodeErr) [*5] |-> decodeErrFlags == laneDecodeErr; endproperty
  property p_rc_done; take |-> ##4 reconfig_done; endproperty
  property p_rc_only; reconfig_done |-> rcCnt_ff == 3'h1; endproperty
  property p_rc_hold; !reconfig_done |-> $stable(reconfig_rd_data); endproperty
  property p_reg_idle; !regRd |=> regRdData == 32'h0; endproperty
  a_lr_set: assert property (p_lr_set) else $error("link reset not flagged");
  a_lr_drop: assert property (p_lr_drop) else $error("link reset flagged early");
  a_lr_rise: assert property (p_lr_rise) else $error("link reset rose unprompted");
  a_mce: assert property (p_mce) else $error("multicast event missed");
  a_mce_only: assert property (p_mce_only) else $error("spurious multicast event");
  a_disp: assert property (p_disp) else $error("disparity flags wrong");
  a_dec: assert property (p_dec) else $error("decode flags wrong");
  a_rc_done: assert property (p_rc_done) else $error("reconfig done late");
  a_rc_only: assert property (p_rc_only) else $error("reconfig done unprompted");
  a_rc_hold: assert property (p_rc_hold) else $error("read data moved");
  a_reg_idle: assert property (p_reg_idle) else $error("register data not idle");
endmodule : pdsp_debug_checker
bind pdsp_debug_port pdsp_debug_checker u_chk (.clk, .rst_n, .laneDispErr, .laneDecodeErr,
  .symValid, .symIsLinkReset, .symIsMce, .symErr, .dispErrFlags, .decodeErrFlags, .rcvdMce,
  .rcvdLinkReset, .reconfig_enable, .reconfig_rd_data, .reconfig_done, .regRd, .regRdData);

//--- test/pdsp_rcfg_master.sv
`timescale 1ns/10ps
// Reconfiguration master on the user side; address and data are scrambled between accesses
module pdsp_rcfg_master (
  input wire logic clk,
  input wire logic reconfig_done,
  output logic reconfig_enable,
  output logic reconfig_write_sel,
  output logic [pdsp_pkg::RCFG_AW-1:0] reconfig_addr,
  output logic [pdsp_pkg::RCFG_DW-1:0] reconfig_wr_data
);
  initial begin
    reconfig_enable = 1'b0;
    reconfig_write_sel = 1'b0;
    reconfig_addr = '0;
    reconfig_wr_data = '0;
  end
  // One access; call right after a rising edge, gap adds idle cycles first
  task access(input logic we, input logic [pdsp_pkg::RCFG_AW-1:0] a,
              input logic [pdsp_pkg::RCFG_DW-1:0] d, input int gap);
    int i;
    begin
      repeat (gap) @(posedge clk);
      reconfig_enable <= 1'b1;
      reconfig_write_sel <= we;
      reconfig_addr <= a;
      reconfig_wr_data <= d;
      @(posedge clk);
      reconfig_enable <= 1'b0;
      reconfig_addr <= ~a;
      reconfig_wr_data <= ~d;
      i = 0;
      // Done is sampled at the edge; no new enable before it is seen
      do begin
        @(posedge clk);
        i++;
      end while (reconfig_done !== 1'b1 && i < 8);
      if (i >= 8) begin
        testbench.n_fail++;
        testbench.wrap_up();
      end
    end
  endtask : access
endmodule : pdsp_rcfg_master

//--- test/testbench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic clk, rst_n, symValid, symIsLinkReset, symIsMce, symErr, regWr, regRd, rdSeen, irq;
  logic enable, writeSel, done, rcvdMce, rcvdLinkReset;
  logic [7:0] laneDispErr, laneDecodeErr, dispErrFlags, decodeErrFlags, dv, cv;
  logic [8:0] addr, a;
  logic [15:0] wrData, rdData, lastRd, d;
  logic [15:0] phyDebug;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [31:0] regQ[$];
  logic [31:0] expReg;
  logic [15:0] expRc;
  logic [15:0] rcQ[$];
  int n_fail, n_tests, seed, i;
  pdsp_debug_port uut (.clk(clk), .rst_n(rst_n), .laneDispErr(laneDispErr),
    .laneDecodeErr(laneDecodeErr), .symValid(symValid), .symIsLinkReset(symIsLinkReset),
    .symIsMce(symIsMce), .symErr(symErr), .dispErrFlags(dispErrFlags),
    .decodeErrFlags(decodeErrFlags), .rcvdMce(rcvdMce), .rcvdLinkReset(rcvdLinkReset),
    .phyDebug(phyDebug), .reconfig_enable(enable), .reconfig_write_sel(writeSel),
    .reconfig_addr(addr), .reconfig_wr_data(wrData), .reconfig_rd_data(rdData),
    .reconfig_done(done), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .irq(irq));
  pdsp_rcfg_master u_master (.clk(clk), .reconfig_done(done), .reconfig_enable(enable),
    .reconfig_write_sel(writeSel), .reconfig_addr(addr), .reconfig_wr_data(wrData));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  // Watcher: results are matched to the oldest note when they appear
  always @(posedge clk) rdSeen <= regRd;
  always @(negedge clk) begin
    // Pop once into a temporary; the macro reads its arguments twice
    if (rdSeen === 1'b1) begin
      expReg = (regQ.size() > 0) ? regQ.pop_front() : 32'hDEAD_BEEF;
      `CHK(regRdData, expReg)
    end
    if (done === 1'b1) begin
      expRc = (rcQ.size() > 0) ? rcQ.pop_front() : 16'hDEAD;
      `CHK(rdData, expRc)
    end
  end
  task wrap_up;
    begin
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask : wrap_up
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task regWrite(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWrData <= dt;
    @(posedge clk);
    regWr <= 1'b0;
    regWrData <= ~dt;
  endtask : regWrite
  task regRead(input logic [3:0] ad, input logic [31:0] ex);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= ad;
    regQ.push_back(ex);
    @(posedge clk);
    regRd <= 1'b0;
  endtask : regRead
  task sym(input logic lr, input logic m, input logic e);
    @(posedge clk);
    symValid <= 1'b1;
    symIsLinkReset <= lr;
    symIsMce <= m;
    symErr <= e;
  endtask : sym
  task symOff;
    @(posedge clk);
    symValid <= 1'b0;
    symIsMce <= 1'b0;
  endtask : symOff
  // Reconfig access; a write leaves the last read data standing
  task rc(input logic we, input logic [8:0] ad, input logic [15:0] dt, input int gap);
    if (!we) lastRd = dt;
    rcQ.push_back(lastRd);
    u_master.access(we, ad, dt, gap);
  endtask : rc
  initial begin
    {symValid, symIsLinkReset, symIsMce, symErr, regWr, regRd, rdSeen} = 7'h00;
    {laneDispErr, laneDecodeErr, regAddr, regWrData} = '0;
    {n_fail, n_tests, lastRd, rst_n} = '0;
    seed = 32'h453D;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    regRead(pdsp_pkg::REG_MASK, 32'h0);
    regRead(4'hF, 32'h0);
    // Clean event then an errored one; only the first counts
    sym(1'b0, 1'b1, 1'b0);
    sym(1'b0, 1'b1, 1'b1);
    symOff();
    regRead(pdsp_pkg::REG_STATUS, 32'h1);
    regWrite(pdsp_pkg::REG_MASK, 32'h1);
    regRead(pdsp_pkg::REG_MASK, 32'h1);
    idle(3);
    `CHK(irq, 1'b1)
    regWrite(pdsp_pkg::REG_STATUS, 32'h1);
    idle(3);
    `CHK(irq, 1'b0)
    // Three clean then an errored reset symbol must not flag; four clean must
    for (i = 0; i < 3; i++) sym(1'b1, 1'b0, 1'b0);
    sym(1'b1, 1'b0, 1'b1);
    for (i = 0; i < 4; i++) sym(1'b1, 1'b0, 1'b0);
    symOff();
    idle(2);
    `CHK(rcvdLinkReset, 1'b1)
    regRead(pdsp_pkg::REG_DEBUG, 32'h402);
    regRead(pdsp_pkg::REG_STATUS, 32'h2);
    sym(1'b0, 1'b1, 1'b0);
    symOff();
    idle(2);
    `CHK(rcvdLinkReset, 1'b0)
    regWrite(pdsp_pkg::REG_STATUS, 32'hF);
    // Random lane errors, bit 0 always set
    dv = $random(seed);
    cv = $random(seed);
    dv[0] = 1'b1;
    cv[0] = 1'b1;
    laneDispErr <= dv;
    laneDecodeErr <= cv;
    idle(6);
    `CHK(dispErrFlags, dv)
    `CHK(decodeErrFlags, cv)
    laneDispErr <= 8'h00;
    laneDecodeErr <= 8'h00;
    idle(6);
    regRead(pdsp_pkg::REG_STATUS, 32'hC);
    regRead(pdsp_pkg::REG_DISP, {24'h0, dv});
    regRead(pdsp_pkg::REG_DEC, {24'h0, cv});
    regWrite(pdsp_pkg::REG_DISP, {24'h0, dv});
    regRead(pdsp_pkg::REG_DISP, 32'h0);
    // Write then read back, alternating prompt and slow starts
    for (i = 0; i < 6; i++) begin
      a = $random(seed);
      d = $random(seed);
      rc(1'b1, a, d, i % 2);
      rc(1'b0, a, d, 0);
    end
    // Reset in mid-run clears the mask
    regWrite(pdsp_pkg::REG_MASK, 32'h5);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    regRead(pdsp_pkg::REG_MASK, 32'h0);
    regRead(pdsp_pkg::REG_DEBUG, 32'h0);
    idle(3);
    wrap_up();
  end
endmodule : testbench
